// >>> pwmst_pkg.sv
// Functional notes
// RULE1 - output goes low when counter low byte equals duty value
// RULE2 - at low byte wrap output goes high only for nonzero duty
// RULE3 - frame index is counter bits 13:8 low six, compared with extension bits 7:2
// RULE4 - selected frame stays high one extra counter clock; others unchanged
// RULE5 - extension bit 7 stretches every odd frame
// RULE6 - extension bit 6 stretches frames 2, 6, 10 up to 62
// RULE7 - extension bit 5 stretches frames 4, 12, 20 up to 60
// RULE8 - bit 4 frames 8,24,40,56; bit 3 frames 16,48; bit 2 frame 32
// RULE9 - selections combine as union; frame 64 is never stretched
// RULE10 - each channel waveform is registered onto its own output pin
// RULE11 - software writes 20H to control to run undivided
// RULE12 - 14-bit up counter holds when stopped and resumes from held value
// RULE13 - counter runs only with control bit 5 set; reset clears control
// RULE14 - 3-bit divider field divides clock by one to eight
// RULE15 - extension bits 1 and 0 have no effect
// RULE16 - new duty and extension values take effect at next frame boundary
// RULE17 - both channels share counter and divider
package pwmst_pkg;

   localparam int          PWMST_NCH        = 2;
   localparam int          PWMST_CNT_W      = 14;
   // register indices; byte address is four times the index
   localparam logic [7:0]  PWMST_IDX_DUTY0  = 8'hF4;
   localparam logic [7:0]  PWMST_IDX_EXT0   = 8'hF5;
   localparam logic [7:0]  PWMST_IDX_DUTY1  = 8'hF6;
   localparam logic [7:0]  PWMST_IDX_EXT1   = 8'hF7;
   localparam logic [7:0]  PWMST_IDX_CTRL   = 8'hF8;
   localparam logic [7:0]  PWMST_IDX_COUNT  = 8'hF9;
   // control field positions
   localparam int          PWMST_RUN_BIT    = 5;
   localparam int          PWMST_DIV_LO     = 6;
   localparam int          PWMST_DIV_HI     = 7;
   localparam int          PWMST_DIV_TOP    = 4;
   localparam int          PWMST_EXT_LSB    = 2;
   localparam logic [7:0]  PWMST_CTRL_RST   = 8'h00;
   localparam logic [7:0]  PWMST_DUTY_RST   = 8'h00;
   localparam logic [7:0]  PWMST_EXT_RST    = 8'h00;
   localparam logic [31:0] PWMST_UNMAPPED   = 32'h0000_0000;

   typedef struct packed {
      logic [7:0]                      ctrl;
      logic [PWMST_NCH-1:0][7:0]       duty;
      logic [PWMST_NCH-1:0][7:0]       ext;
      logic [PWMST_NCH-1:0][7:0]       duty_a;
      logic [PWMST_NCH-1:0][5:0]       ext_a;
      logic [PWMST_NCH-1:0]            str;
      logic [PWMST_NCH-1:0]            pwm;
      logic [PWMST_CNT_W-1:0]          cnt;
      logic [2:0]                      pre;
      logic                            ack;
      logic [31:0]                     rdata;
   } pwmst_state_t;

   localparam pwmst_state_t PWMST_STATE_RST = '0;

endpackage

// >>> pwmst_top.sv
`timescale 1ns/1ps
module pwmst_top
   import pwmst_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic [9:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   output logic             channel0_duty_value_o,
   output logic             channel1_duty_value_o
);

   // frame index f: cycle n is f=n for n<64, cycle 64 is f=0
   function automatic logic stretch_sel(input logic [5:0] e, input logic [5:0] f);
      logic s;
      s = 1'b0;
      // RULE5 odd frames
      s = s | (e[5] & f[0]);
      // RULE6 steps of four
      s = s | (e[4] & (f[1:0] == 2'h2));
      // RULE7 steps of eight
      s = s | (e[3] & (f[2:0] == 3'h4));
      // RULE8 remaining bits
      s = s | (e[2] & (f[3:0] == 4'h8));
      s = s | (e[1] & (f[4:0] == 5'h10));
      s = s | (e[0] & (f == 6'h20));
      return s;
   endfunction

   pwmst_state_t q;
   pwmst_state_t d;

   logic [7:0]             idx;
   logic                   req;
   logic                   run;
   logic [2:0]             div;
   logic                   tick;
   logic [PWMST_CNT_W-1:0] nxt;
   logic                   wrap;
   logic [8:0]             stop_at;

   assign idx = address_i[9:2];
   assign req = read_i | write_i;
   // RULE13 run bit gates the counter
   assign run = q.ctrl[PWMST_RUN_BIT];
   assign div = {q.ctrl[PWMST_DIV_TOP], q.ctrl[PWMST_DIV_HI], q.ctrl[PWMST_DIV_LO]};
   // RULE14 divider yields one tick per div+1 clocks
   // at-or-above, so a smaller field written mid-count cannot wrap it
   assign tick = run & (q.pre >= div);
   assign nxt = q.cnt + 14'h0001;
   assign wrap = (nxt[7:0] == 8'h00);

   // frozen clock enable must hold off the bus too
   assign waitrequest_o = req & (~q.ack | ~ce_i);
   assign readdata_o = q.rdata;
   // RULE10 pins come straight from flops
   assign channel0_duty_value_o = q.pwm[0];
   assign channel1_duty_value_o = q.pwm[1];

   always_comb
   begin
      d = q;
      stop_at = 9'h000;
      d.ack = req & ~q.ack;
      if (req & q.ack & write_i & byteenable_i[0])
      begin
         unique case (idx)
            PWMST_IDX_DUTY0: d.duty[0] = writedata_i[7:0];
            PWMST_IDX_EXT0:  d.ext[0] = writedata_i[7:0];
            PWMST_IDX_DUTY1: d.duty[1] = writedata_i[7:0];
            PWMST_IDX_EXT1:  d.ext[1] = writedata_i[7:0];
            PWMST_IDX_CTRL:  d.ctrl = writedata_i[7:0];
            default:         d.ctrl = q.ctrl;
         endcase
      end
      if (req & ~q.ack & read_i)
      begin
         unique case (idx)
            PWMST_IDX_DUTY0: d.rdata = {24'h000000, q.duty[0]};
            PWMST_IDX_EXT0:  d.rdata = {24'h000000, q.ext[0]};
            PWMST_IDX_DUTY1: d.rdata = {24'h000000, q.duty[1]};
            PWMST_IDX_EXT1:  d.rdata = {24'h000000, q.ext[1]};
            PWMST_IDX_CTRL:  d.rdata = {24'h000000, q.ctrl};
            PWMST_IDX_COUNT: d.rdata = {18'h00000, q.cnt};
            default:         d.rdata = PWMST_UNMAPPED;
         endcase
      end
      // RULE12 stopped counter and divider keep their values
      if (run)
      begin
         d.pre = tick ? 3'h0 : q.pre + 3'h1;
      end
      if (tick)
      begin
         // RULE17 one counter serves both channels
         d.cnt = nxt;
         for (int c = 0; c < PWMST_NCH; c++)
         begin
            if (wrap)
            begin
               // RULE16 shadow copies load only at frame start
               d.duty_a[c] = q.duty[c];
               // RULE15 bits 1:0 dropped here
               d.ext_a[c] = q.ext[c][7:PWMST_EXT_LSB];
               // RULE3 frame index versus extension
               // RULE9 union of all selections
               d.str[c] = stretch_sel(q.ext[c][7:PWMST_EXT_LSB], nxt[13:8]);
               // RULE2 zero duty stays low
               d.pwm[c] = (q.duty[c] != 8'h00);
            end
            else
            begin
               // RULE4 selected frame ends one clock later
               stop_at = {1'b0, q.duty_a[c]} + {8'h00, q.str[c]};
               // RULE1 fall at duty match
               if ({1'b0, nxt[7:0]} == stop_at)
               begin
                  d.pwm[c] = 1'b0;
               end
            end
         end
      end
   end

   // RULE13 reset clears control and pins
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         q <= PWMST_STATE_RST;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   sequence s_wrap_tick;
      ce_i && tick && wrap;
   endsequence

   sequence s_mid_tick;
      ce_i && tick && !wrap;
   endsequence

   sequence s_div2_tick;
      ce_i && run && tick && div == 3'h1;
   endsequence

   property p_cnt_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !run) |=> (q.cnt == $past(q.cnt));
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) // RULE12
      else $error("counter moved while stopped");

   property p_cnt_step;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && tick) |=> (q.cnt == 14'($past(q.cnt) + 14'h0001));
   endproperty
   a_cnt_step: assert property (p_cnt_step) // RULE12
      else $error("counter did not advance by one");

   property p_div_gap;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_div2_tick ##1 (div == 3'h1) |-> !tick;
   endproperty
   a_div_gap: assert property (p_div_gap) // RULE14
      else $error("divide by two ticked twice in a row");

   property p_div_space;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_div2_tick ##1 (ce_i && run && div == 3'h1) ##1 (run && div == 3'h1)
         |-> tick;
   endproperty
   a_div_space: assert property (p_div_space) // RULE14
      else $error("divide by two spacing wrong");

   property p_pre_range;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && run) |=> (q.pre <= $past(div));
   endproperty
   a_pre_range: assert property (p_pre_range) // RULE14
      else $error("divider count beyond field");

   property p_rise0;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.duty[0] != 8'h00) |=> channel0_duty_value_o;
   endproperty
   a_rise0: assert property (p_rise0) // RULE2
      else $error("channel 0 not high at frame start");

   property p_zero1;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.duty[1] == 8'h00) |=> !channel1_duty_value_o;
   endproperty
   a_zero1: assert property (p_zero1) // RULE2
      else $error("channel 1 high with zero duty");

   property p_rise1;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.duty[1] != 8'h00) |=> channel1_duty_value_o;
   endproperty
   a_rise1: assert property (p_rise1) // RULE2
      else $error("channel 1 not high at frame start");

   property p_zero0;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.duty[0] == 8'h00) |=> !channel0_duty_value_o;
   endproperty
   a_zero0: assert property (p_zero0) // RULE2
      else $error("channel 0 high with zero duty");

   property p_fall0;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_mid_tick ##0 (!q.str[0] && nxt[7:0] == q.duty_a[0]) |=> !channel0_duty_value_o;
   endproperty
   a_fall0: assert property (p_fall0) // RULE1
      else $error("channel 0 missed duty match");

   property p_fall1;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_mid_tick ##0 (!q.str[1] && nxt[7:0] == q.duty_a[1]) |=> !channel1_duty_value_o;
   endproperty
   a_fall1: assert property (p_fall1) // RULE1
      else $error("channel 1 missed duty match");

   property p_stretch0;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_mid_tick ##0 (q.str[0] && channel0_duty_value_o && nxt[7:0] == q.duty_a[0])
         |=> channel0_duty_value_o;
   endproperty
   a_stretch0: assert property (p_stretch0) // RULE4
      else $error("stretched frame fell at duty value");

   property p_odd_sel;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.ext[0][7] && nxt[8]) |=> q.str[0];
   endproperty
   a_odd_sel: assert property (p_odd_sel) // RULE5
      else $error("odd frame not selected");

   property p_sel_four;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.ext[1][6] && nxt[9:8] == 2'h2) |=> q.str[1];
   endproperty
   a_sel_four: assert property (p_sel_four) // RULE6
      else $error("step of four frame not selected");

   property p_sel_eight;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.ext[1][5] && nxt[10:8] == 3'h4) |=> q.str[1];
   endproperty
   a_sel_eight: assert property (p_sel_eight) // RULE7
      else $error("step of eight frame not selected");

   property p_sel_sixteen;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.ext[1][3] && nxt[12:8] == 5'h10) |=> q.str[1];
   endproperty
   a_sel_sixteen: assert property (p_sel_sixteen) // RULE8
      else $error("frame 16 or 48 not selected");

   property p_sel_sparse;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.ext[0][2] && nxt[13:8] == 6'h20) |=> q.str[0];
   endproperty
   a_sel_sparse: assert property (p_sel_sparse) // RULE8
      else $error("frame 32 not selected");

   property p_last_frame;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (nxt[13:8] == 6'h00) |=> (q.str == 2'b00);
   endproperty
   a_last_frame: assert property (p_last_frame) // RULE9
      else $error("frame 64 was stretched");

   property p_low_bits;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_wrap_tick ##0 (q.ext[1][7:2] == 6'h00) |=> !q.str[1];
   endproperty
   a_low_bits: assert property (p_low_bits) // RULE15
      else $error("low extension bits caused stretch");

   property p_shadow;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !(tick && wrap)) |=> $stable(q.duty_a) && $stable(q.ext_a);
   endproperty
   a_shadow: assert property (p_shadow) // RULE16
      else $error("shadow changed inside a frame");

   property p_reset;
      @(posedge mclk_i)
      !rst_n_i |=> (q.ctrl == PWMST_CTRL_RST) && !channel0_duty_value_o && !channel1_duty_value_o;
   endproperty
   a_reset: assert property (p_reset) // RULE13
      else $error("reset left control or pins set");

   property p_bus_ack;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (req && ce_i && !q.ack) |=> (!waitrequest_o || !ce_i || !req);
   endproperty
   a_bus_ack: assert property (p_bus_ack)
      else $error("bus answer later than one wait cycle");

endmodule

// >>> pwmst_meter.sv
`timescale 1ns/1ps
// load on one pin: logs each high time in mclk cycles
module pwmst_meter
(
   input  wire logic mclk_i,
   input  wire logic pwm_i,
   output int        n_o
);
   int          n_q = 0;
   logic [15:0] run_q = '0;
   logic [15:0] w_q [256];
   assign n_o = n_q;
   always @(posedge mclk_i)
   begin
      if (pwm_i === 1'b1)
         run_q <= run_q + 16'h0001;
      else if (run_q != 16'h0000)
      begin
         w_q[n_q[7:0]] <= run_q;
         n_q           <= n_q + 1;
         run_q         <= 16'h0000;
      end
   end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench
   import pwmst_pkg::*;
;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        ce_i = 1'b1;
   logic [9:0]  address_i = '0;
   logic        read_i = 1'b0;
   logic        write_i = 1'b0;
   logic [31:0] writedata_i = '0;
   logic [3:0]  byteenable_i = 4'hF;
   logic [31:0] readdata_o, q, a;
   logic        waitrequest_o, channel0_duty_value_o, channel1_duty_value_o;
   int          n0, n1, n, n_errors = 0, check_count = 0;
   logic [7:0]  cv [3] = '{8'h60, 8'h30, 8'hF0};
   int          rt [3] = '{2, 5, 8};

   pwmst_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
      .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .channel0_duty_value_o(channel0_duty_value_o), .channel1_duty_value_o(channel1_duty_value_o));
   pwmst_meter m0 (.mclk_i(mclk_i), .pwm_i(channel0_duty_value_o), .n_o(n0));
   pwmst_meter m1 (.mclk_i(mclk_i), .pwm_i(channel1_duty_value_o), .n_o(n1));

   always #4 mclk_i = ~mclk_i;

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         n_errors++;
         $display("mismatch at %0t: value %h, wanted %h", $time, s, e);
      end
   endtask

   // idle edge first, so a release and a new request never share a step
   task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
                      input logic [3:0] be);
      @(posedge mclk_i);
      address_i    <= {ix, 2'b00};
      writedata_i  <= {24'h000000, d};
      byteenable_i <= be;
      write_i      <= w;
      read_i       <= ~w;
      do
         @(posedge mclk_i);
      while (waitrequest_o !== 1'b0);
      q = readdata_o;
      write_i <= 1'b0;
      read_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      bus(1'b1, ix, d, 4'hF);
   endtask

   task automatic rd(input logic [7:0] ix, input logic [31:0] e);
      bus(1'b0, ix, 8'h00, 4'hF);
      chk(q, e);
   endtask

   // stretch pick for a frame index; index 0 is never picked
   function automatic logic st(input logic [7:0] e, input int f);
      st = 1'b0;
      for (int b = 0; b < 6; b++)
         if (e[7-b] && f % (2 << b) == (1 << b))
            st = 1'b1;
   endfunction

   task automatic final_report;
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge mclk_i);
      n_errors++;
      final_report;
   end

   initial
   begin
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int i = 'hF4; i <= 'hF9; i++)
         rd(i[7:0], 32'h0);
      rd(8'h10, 32'h0);
      bus(1'b1, PWMST_IDX_DUTY0, 8'h55, 4'h0);
      rd(PWMST_IDX_DUTY0, 32'h0);
      $display("end of reset test");
      wr(PWMST_IDX_DUTY0, 8'h40);
      wr(PWMST_IDX_EXT0, 8'h84);
      wr(PWMST_IDX_DUTY1, 8'h80);
      wr(PWMST_IDX_EXT1, 8'h7B);
      wr(PWMST_IDX_CTRL, 8'h20);
      while (n0 < 64)
         @(posedge mclk_i);
      // new values only from the next wrap, so pulse 64 is frame 1 again
      wr(PWMST_IDX_EXT0, 8'hFC);
      wr(PWMST_IDX_EXT1, 8'h03);
      while (n1 < 128)
         @(posedge mclk_i);
      for (int k = 0; k < 128; k++)
      begin
         chk(m0.w_q[k], 16'h0040 + st(k < 64 ? 8'h84 : 8'hFC, (k + 1) % 64));
         chk(m1.w_q[k], 16'h0080 + st(k < 64 ? 8'h7B : 8'h03, (k + 1) % 64));
      end
      $display("end of stretch test");
      wr(PWMST_IDX_DUTY0, 8'h00);
      repeat (300) @(posedge mclk_i);
      n = n0;
      repeat (600) @(posedge mclk_i);
      chk(n0, n);
      wr(PWMST_IDX_CTRL, 8'h00);
      bus(1'b0, PWMST_IDX_COUNT, 8'h00, 4'hF);
      a = q;
      repeat (20) @(posedge mclk_i);
      rd(PWMST_IDX_COUNT, a);
      chk(a[31:14], 32'h0);
      wr(PWMST_IDX_CTRL, 8'h20);
      bus(1'b0, PWMST_IDX_COUNT, 8'h00, 4'hF);
      chk(q > a, 32'h1);
      // three enabled ticks reach the next sample; twenty frozen ones do not
      a = q;
      ce_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
      ce_i <= 1'b1;
      rd(PWMST_IDX_COUNT, {18'h00000, a[13:0] + 14'h0003});
      $display("end of hold test");
      for (int i = 0; i < 3; i++)
      begin
         wr(PWMST_IDX_CTRL, cv[i]);
         rd(PWMST_IDX_CTRL, {24'h000000, cv[i]});
         n = n1;
         while (n1 < n + 2)
            @(posedge mclk_i);
         chk(m1.w_q[n1 - 1], rt[i] * 128);
      end
      $display("end of divider test");
      final_report;
   end
endmodule
